// *** logic/video_mode_selector.sv ***
// video mode selector: local generation or genlock overlay
`timescale 1ns/100ps
`default_nettype none
module video_mode_selector
  import video_mode_pkg::*;
#(
  parameter int timeout_cycles = line_cycles * sync_timeout_lines
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // mode command from software
  input wire logic [1:0] mode_cmd_in,
  // input video sync pin, and generator phase lock indication from pin
  input wire logic ext_sync_in,
  input wire logic gen_locked_in,
  // mode outputs
  output logic genlock_mode_out,
  output logic local_mode_out,
  output logic overlay_enable_out,
  output logic black_background_out,
  output logic auto_mode_out
);
  // parameter range checks
  if (timeout_cycles < 2) begin : g_bad_timeout
    $error("timeout_cycles too small");
  end
  localparam logic [1:0] cmd_reserved = 2'h3;

  logic rst_s1_q, rst_n_q;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // pin synchronisers
  logic [1:0] sync_s_q, lock_s_q;
  logic sync_prev_q, sync_pulse;
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sync_s_q <= '0;
      lock_s_q <= '0;
      sync_prev_q <= 1'b0;
    end else begin
      sync_s_q <= {sync_s_q[0], ext_sync_in};
      lock_s_q <= {lock_s_q[0], gen_locked_in};
      sync_prev_q <= sync_s_q[1];
    end
  end
  assign sync_pulse = sync_s_q[1] & ~sync_prev_q;

  logic present;
  sync_qualifier #(
    .count_max(qualify_periods),
    .timeout_cycles(timeout_cycles)
  ) u_qual (
    .clk_in(clk_in),
    .rst_n_in(rst_n_q),
    .sync_pulse_in(sync_pulse),
    .present_out(present)
  );

  mode_cmd_t cmd_q, cmd_d;
  mode_state_t state_q, state_d;
  logic want_genlock;
  always_comb begin
    cmd_d = cmd_q;
    if (mode_cmd_in == cmd_auto || mode_cmd_in == cmd_local ||
        mode_cmd_in == cmd_genlock)
      cmd_d = mode_cmd_t'(mode_cmd_in);
    unique case (cmd_q)
      cmd_local: want_genlock = 1'b0;
      cmd_genlock: want_genlock = 1'b1;
      default: want_genlock = present;
    endcase
    state_d = state_q;
    unique case (state_q)
      st_local: if (want_genlock) state_d = st_sync;
      st_sync: begin
        if (!want_genlock) state_d = st_local;
        else if (lock_s_q[1]) state_d = st_overlay;
      end
      st_overlay: begin
        if (!want_genlock) state_d = st_local;
        else if (!lock_s_q[1] && cmd_q != cmd_genlock)
          state_d = st_sync;
      end
      default: state_d = st_local;
    endcase
  end
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cmd_q <= cmd_auto;
      state_q <= st_local;
    end else begin
      cmd_q <= cmd_d;
      state_q <= state_d;
    end
  end

  logic gl_q, gl_d, ov_q, ov_d;
  always_comb begin
    gl_d = (state_d != st_local);
    ov_d = (state_d == st_overlay);
  end
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      gl_q <= 1'b0;
      ov_q <= 1'b0;
    end else begin
      gl_q <= gl_d;
      ov_q <= ov_d;
    end
  end
  assign genlock_mode_out = gl_q;
  assign local_mode_out = ~gl_q;
  assign black_background_out = ~gl_q;
  assign overlay_enable_out = ov_q;
  assign auto_mode_out = (cmd_q == cmd_auto);

  a_reset_auto: assert property (@(posedge clk_in)
    $rose(rst_n_q) |-> auto_mode_out) else $error("not auto after reset");
  a_forced_local: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    cmd_q == cmd_local |=> !genlock_mode_out)
    else $error("forced local left");
  a_forced_genlock: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    cmd_q == cmd_genlock && $past(cmd_q) == cmd_genlock && genlock_mode_out
    |=> genlock_mode_out) else $error("forced genlock fell back");
  a_overlay_lock: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    $rose(overlay_enable_out) |-> $past(lock_s_q[1]))
    else $error("overlay without lock");
  a_auto_absent: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    cmd_q == cmd_auto && !present && mode_cmd_in == cmd_auto
    |=> !genlock_mode_out) else $error("auto not local");
  a_auto_present: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    cmd_q == cmd_auto && present && mode_cmd_in == cmd_auto
    |=> genlock_mode_out) else $error("auto not genlock");
  a_black_local: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    local_mode_out |-> black_background_out && !overlay_enable_out)
    else $error("local not black");
  a_mode_excl: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    genlock_mode_out != local_mode_out) else $error("mode clash");

  // command register behaviour
  a_cmd_auto: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    mode_cmd_in == cmd_auto |=> auto_mode_out)
    else $error("auto command not taken");
  a_cmd_forced: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    (mode_cmd_in == cmd_local || mode_cmd_in == cmd_genlock)
    |=> !auto_mode_out)
    else $error("forced command not taken");
  a_code_ignored: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    mode_cmd_in == cmd_reserved |=> $stable(auto_mode_out))
    else $error("reserved code changed mode");

  // forced local held for two edges
  sequence s_force_local;
    cmd_q == cmd_local ##1 cmd_q == cmd_local;
  endsequence
  property p_force_local;
    @(posedge clk_in) disable iff (!rst_n_q)
    s_force_local |-> local_mode_out && !overlay_enable_out;
  endproperty
  a_local_forced: assert property (p_force_local)
    else $error("forced local not local");

  // overlay drops on lost lock unless genlock is forced
  sequence s_lock_lost;
    overlay_enable_out && !lock_s_q[1] && cmd_q != cmd_genlock;
  endsequence
  property p_lock_lost;
    @(posedge clk_in) disable iff (!rst_n_q)
    s_lock_lost |=> !overlay_enable_out;
  endproperty
  a_lock_drop: assert property (p_lock_lost)
    else $error("overlay kept without lock");

  // sync state moves to overlay once locked
  sequence s_locked_sync;
    genlock_mode_out && !overlay_enable_out && lock_s_q[1] && want_genlock;
  endsequence
  property p_sync_overlay;
    @(posedge clk_in) disable iff (!rst_n_q)
    s_locked_sync |=> overlay_enable_out;
  endproperty
  a_sync_overlay: assert property (p_sync_overlay)
    else $error("locked but no overlay");

  // local state leaves for sync when genlock is wanted
  sequence s_local_want;
    !genlock_mode_out && want_genlock;
  endsequence
  property p_local_sync;
    @(posedge clk_in) disable iff (!rst_n_q)
    s_local_want |=> genlock_mode_out && !overlay_enable_out;
  endproperty
  a_local_sync: assert property (p_local_sync)
    else $error("local did not enter sync");

  // forced genlock keeps genlock output
  a_genlock_hold: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    cmd_q == cmd_genlock && genlock_mode_out |=> genlock_mode_out)
    else $error("forced genlock dropped");

  // presence only changes on qualified events
  a_absent_hold: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    !present && !sync_pulse |=> !present)
    else $error("presence without sync");
  a_present_sync: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    $rose(present) |-> $past(sync_pulse))
    else $error("presence rose without pulse");
endmodule // video_mode_selector
`default_nettype wire

// *** logic/video_mode_pkg.sv ***
// constants and types for the video mode selector
// Operation
// - after reset the selector starts in automatic mode.
// - automatic mode with no input video selects local generation.
// - local mode outputs generated timing, characters over black background.
// - automatic mode with input video present switches to genlock overlay.
// - overlay is enabled only once the generator is locked to input.
// - automatic mode keeps monitoring input and switches as needed.
// - software command forces local or genlock, disabling automatic switching.
// - forced genlock never falls back to local on dropouts.
package video_mode_pkg;
  typedef enum logic [1:0] {
    cmd_auto = 2'h0,
    cmd_local = 2'h1,
    cmd_genlock = 2'h2
  } mode_cmd_t;
  typedef enum logic [2:0] {
    st_local = 3'h1,
    st_sync = 3'h2,
    st_overlay = 3'h4
  } mode_state_t;
  localparam int qualify_periods = 4;
  localparam int line_time_ns = 64000;
  localparam int clk_period_ns = 8;
  localparam int line_cycles = line_time_ns / clk_period_ns;
  localparam int sync_timeout_lines = 2;
  localparam int lock_lines = 3;
endpackage : video_mode_pkg

// *** logic/sync_qualifier.sv ***
// counts consecutive sync periods of presence or absence
`timescale 1ns/100ps
`default_nettype none
module sync_qualifier
  import video_mode_pkg::*;
#(
  parameter int count_max = qualify_periods,
  parameter int timeout_cycles = line_cycles * sync_timeout_lines
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // sync pulse already synchronised, one cycle
  input wire logic sync_pulse_in,
  // qualified presence level
  output logic present_out
);
  if (count_max < 1 || count_max > 255) begin : g_bad_count
    $error("count_max out of range");
  end
  if (timeout_cycles < 2) begin : g_bad_timeout
    $error("timeout_cycles too small");
  end
  logic [31:0] timer_q, timer_d;
  logic [7:0] good_q, good_d, bad_q, bad_d;
  logic present_q, present_d;
  always_comb begin
    timer_d = timer_q;
    good_d = good_q;
    bad_d = bad_q;
    present_d = present_q;
    if (sync_pulse_in) begin
      timer_d = '0;
      bad_d = '0;
      if (good_q < 8'(count_max)) good_d = good_q + 8'h01;
      else present_d = 1'b1;
    end else if (timer_q >= 32'(timeout_cycles)) begin
      timer_d = '0;
      good_d = '0;
      if (bad_q < 8'(count_max)) bad_d = bad_q + 8'h01;
      else present_d = 1'b0;
    end else begin
      timer_d = timer_q + 32'h1;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timer_q <= '0;
      good_q <= '0;
      bad_q <= '0;
      present_q <= 1'b0;
    end else begin
      timer_q <= timer_d;
      good_q <= good_d;
      bad_q <= bad_d;
      present_q <= present_d;
    end
  end
  assign present_out = present_q;
endmodule // sync_qualifier
`default_nettype wire

// *** verif/video_source_model.sv ***
// behavioural incoming video source: sync pulses and lock indication
`timescale 1ns/100ps
`default_nettype none
module video_source_model
  import video_mode_pkg::*;
(
  // clock
  input wire logic clk_in,
  // source control from the bench
  input wire logic on_in,
  input wire logic [7:0] period_in,
  // video pins
  output logic sync_out = 1'b0,
  output logic locked_out = 1'b0
);
  int cnt = 0;
  int seen = 0;
  always @(posedge clk_in) begin
    if (!on_in) begin
      cnt <= 0;
      seen <= 0;
      sync_out <= 1'b0;
      locked_out <= 1'b0;
    end else begin
      cnt <= (cnt + 1 >= int'(period_in)) ? 0 : cnt + 1;
      sync_out <= (cnt < 2);
      if (cnt == 0 && seen < lock_lines) seen <= seen + 1;
      locked_out <= (seen >= lock_lines);
    end
  end
endmodule // video_source_model
`default_nettype wire

// *** verif/video_mode_selector_tb_top.sv ***
// self-checking bench for the video mode selector
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module video_mode_selector_tb_top;
  import video_mode_pkg::*;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [1:0] cmd = 2'h0;
  logic vid_on = 1'b0;
  logic [7:0] period = 8'h14;
  logic sync_w, lock_w, g, l, o, b, a;
  logic mon_on = 1'b0;
  logic [4:0] outs, last, e_v;
  logic [4:0] exp_q[$];
  int failures = 0;
  int checks_done = 0;
  assign outs = {a, g, l, o, b};
  video_source_model video_source_model_i (.clk_in(clk_in), .on_in(vid_on),
    .period_in(period), .sync_out(sync_w), .locked_out(lock_w));
  video_mode_selector #(.timeout_cycles(50)) video_mode_selector_i (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .mode_cmd_in(cmd),
    .ext_sync_in(sync_w), .gen_locked_in(lock_w), .genlock_mode_out(g),
    .local_mode_out(l), .overlay_enable_out(o), .black_background_out(b),
    .auto_mode_out(a));
  initial begin
    forever #4 clk_in = ~clk_in;
  end
  // expected outputs: st 0 local, 1 sync, 2 overlay
  function automatic logic [4:0] ev(input logic au, input int st);
    return {au, st != 0, st == 0, st == 2, st == 0};
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic drain(input int lim);
    for (int i = 0; i < lim && exp_q.size() != 0; i++) step(1);
    `CHK("pending", 0, exp_q.size())
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // every output change must match the oldest note
  always @(posedge clk_in) begin
    if (mon_on && outs !== last) begin
      e_v = exp_q.size() != 0 ? exp_q.pop_front() : ~outs;
      `CHK("outputs", e_v, outs)
    end
    last <= outs;
  end
  initial begin
    step(20000);
    failures++;
    test_done;
  end
  initial begin
    void'($urandom(32'hbfa0a11f));
    step(4);
    reset_n_in = 1'b1;
    step(3);
    `CHK("reset", ev(1, 0), outs)
    mon_on = 1'b1;
    period = 8'($urandom_range(40, 10));
    vid_on = 1'b1;
    step(3 * int'(period));
    vid_on = 1'b0;
    step(400);
    exp_q.push_back(ev(1, 1));
    exp_q.push_back(ev(1, 2));
    vid_on = 1'b1;
    drain(400);
    exp_q.push_back(ev(1, 1));
    exp_q.push_back(ev(1, 0));
    vid_on = 1'b0;
    drain(600);
    exp_q.push_back(ev(0, 0));
    exp_q.push_back(ev(0, 1));
    cmd = cmd_genlock;
    drain(10);
    exp_q.push_back(ev(0, 2));
    vid_on = 1'b1;
    drain(400);
    vid_on = 1'b0;
    step(20);
    `CHK("forced overlay", ev(0, 2), outs)
    step(600);
    `CHK("forced hold", ev(0, 2), outs)
    exp_q.push_back(ev(0, 0));
    cmd = cmd_local;
    drain(10);
    vid_on = 1'b1;
    step(400);
    cmd = 2'h3;
    step(50);
    exp_q.push_back(ev(1, 0));
    exp_q.push_back(ev(1, 1));
    exp_q.push_back(ev(1, 2));
    cmd = cmd_auto;
    drain(20);
    test_done;
  end
endmodule // video_mode_selector_tb_top
`default_nettype wire
